//--- soft_output_defs.svh
// Register offsets, reset values and field constants for the soft output register block
`ifndef SOFT_OUTPUT_DEFS_SVH
`define SOFT_OUTPUT_DEFS_SVH
`define OFS_BIT_SELECTOR 4'h0
`define OFS_BIT_VALUE 4'h4
`define OFS_WORD_VALUE 4'h8
`define OFS_WORD_MASK 4'hc
`define OUT_RESET 32'h00000000
`define MASK_RESET 32'hffffffff
`define UNMAPPED_READ 32'h00000000
`endif

//--- soft_output_pkg.sv
// Types shared by the soft output register block
package soft_output_pkg;
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avmm_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } avmm_rsp_s;
  typedef enum logic [1:0] {ST_IDLE, ST_DONE} bus_state_e;
endpackage

//--- user_output_register.sv
// Software-controlled soft output register with bit and word write paths
`timescale 1ns/100ps
`default_nettype none
`include "soft_output_defs.svh"
// ==========================================================
// How it works
// - The bit selector value N picks bit N of the soft output register, counting up from 0.
// - Writing the bit value loads that boolean into the selected bit and leaves the rest alone.
// - Writing the word value drives each register bit from the matching written bit.
// - Bit 0 of the word value maps to output bit 0, higher bits to higher outputs.
// - A word write changes only the bits whose write mask bit is one.
// - The write mask takes any pattern and is readable and writable by software.
// - Single-bit writes ignore the write mask and update the selected bit whenever byte lane 0 is enabled.
// - Each soft output bit drives its line source output with the current register state.
module user_output_register
  import soft_output_pkg::*;
#(
  parameter int NUM_OUTPUTS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire avmm_req_s bus_req,
  output avmm_rsp_s bus_rsp,
  output logic [NUM_OUTPUTS-1:0] line_drive_source
);
  localparam int SEL_W = (NUM_OUTPUTS > 1) ? $clog2(NUM_OUTPUTS) : 1;

  // ==========================================================
  // State
  logic [NUM_OUTPUTS-1:0] out_reg, out_next;
  logic [NUM_OUTPUTS-1:0] mask_reg, mask_next;
  logic [SEL_W-1:0] sel_reg, sel_next;
  logic [31:0] rdata_reg, rdata_next;
  bus_state_e state_reg, state_next;
  logic [31:0] wd;
  logic [31:0] wbe;
  logic [31:0] out_word, mask_word;
  logic fire;

  always_comb begin
    wbe = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
           {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};
    wd = bus_req.writedata;
    out_word = 32'h00000000;
    out_word[NUM_OUTPUTS-1:0] = out_reg;
    mask_word = 32'h00000000;
    mask_word[NUM_OUTPUTS-1:0] = mask_reg;
  end

  // ==========================================================
  // Bus slave: one wait cycle per access, answer in the second
  assign fire = (state_reg == ST_IDLE) && (bus_req.read || bus_req.write);

  always_comb begin
    out_next = out_reg;
    mask_next = mask_reg;
    sel_next = sel_reg;
    rdata_next = rdata_reg;
    state_next = ST_IDLE;
    if (fire) begin
      state_next = ST_DONE;
      if (bus_req.write) begin
        unique case (bus_req.address)
          `OFS_BIT_SELECTOR: begin
            // Out-of-range selector values are refused by ignoring the write, so the old selector stays
            if (wbe[0] && (wd[SEL_W-1:0] < NUM_OUTPUTS) && (wd[31:SEL_W] == '0))
              sel_next = wd[SEL_W-1:0];
          end
          `OFS_BIT_VALUE: begin
            if (wbe[0])
              out_next[sel_reg] = wd[0];
          end
          `OFS_WORD_VALUE: begin
            // Byte lanes not enabled also leave bits untouched
            out_next = (out_reg & ~(mask_reg & wbe[NUM_OUTPUTS-1:0]))
                     | (wd[NUM_OUTPUTS-1:0] & mask_reg & wbe[NUM_OUTPUTS-1:0]);
          end
          `OFS_WORD_MASK: begin
            mask_next = (mask_reg & ~wbe[NUM_OUTPUTS-1:0])
                      | (wd[NUM_OUTPUTS-1:0] & wbe[NUM_OUTPUTS-1:0]);
          end
          default: begin
          end
        endcase
      end else begin
        unique case (bus_req.address)
          `OFS_BIT_SELECTOR: rdata_next = 32'(sel_reg);
          `OFS_BIT_VALUE: rdata_next = {31'h0, out_reg[sel_reg]};
          `OFS_WORD_VALUE: rdata_next = out_word;
          `OFS_WORD_MASK: rdata_next = mask_word;
          default: rdata_next = `UNMAPPED_READ;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= NUM_OUTPUTS'(`OUT_RESET);
      mask_reg <= NUM_OUTPUTS'(`MASK_RESET);
      sel_reg <= '0;
      rdata_reg <= 32'h00000000;
      state_reg <= ST_IDLE;
    end else begin
      out_reg <= out_next;
      mask_reg <= mask_next;
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  logic wait_reg, wait_next;
  logic [NUM_OUTPUTS-1:0] line_reg, line_next;

  // Lines load from the next value so they never lag the register
  always_comb begin
    wait_next = !fire;
    line_next = out_next;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_reg <= 1'b1;
      line_reg <= '0;
    end else begin
      wait_reg <= wait_next;
      line_reg <= line_next;
    end
  end

  assign bus_rsp = '{readdata: rdata_reg, waitrequest: wait_reg};
  assign line_drive_source = line_reg;

  // ==========================================================
  // Checks
  a_line_follows_reg: assert property (@(posedge clk) disable iff (!rst_n)
    line_drive_source == out_reg)
    else $error("line source differs from register");

  a_bit_write_sel: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_VALUE && bus_req.byteenable[0]
    |=> out_reg[$past(sel_reg)] == $past(bus_req.writedata[0]))
    else $error("bit write not loaded");

  a_bit_write_others: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_VALUE
    |=> ((out_reg ^ $past(out_reg)) & ~(NUM_OUTPUTS'(1) << $past(sel_reg))) == '0)
    else $error("bit write touched other bits");

  a_bit_ignores_mask: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_VALUE && bus_req.byteenable[0]
    && mask_reg == '0 |=> out_reg[$past(sel_reg)] == $past(bus_req.writedata[0]))
    else $error("bit write blocked by mask");

  a_word_full_mask: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE && &mask_reg
    && &bus_req.byteenable |=> out_reg == $past(bus_req.writedata[NUM_OUTPUTS-1:0]))
    else $error("word write not loaded");

  a_word_mask_holds: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE
    |=> ((out_reg ^ $past(out_reg)) & ~$past(mask_reg)) == '0)
    else $error("masked bit changed");

  a_lsb_maps_bit0: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE && mask_reg[0]
    && bus_req.byteenable[0] |=> out_reg[0] == $past(bus_req.writedata[0]))
    else $error("lsb not on bit 0");

  a_mask_readback: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read && bus_req.address == `OFS_WORD_MASK
    |=> !bus_rsp.waitrequest && bus_rsp.readdata == mask_word)
    else $error("mask readback wrong");

  a_word_readback: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read && bus_req.address == `OFS_WORD_VALUE
    |=> bus_rsp.readdata == $past(out_word))
    else $error("word readback wrong");

  a_sel_in_range: assert property (@(posedge clk) disable iff (!rst_n)
    sel_reg < NUM_OUTPUTS)
    else $error("selector out of range");

  a_sel_write_load: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_SELECTOR
    && bus_req.byteenable[0] && bus_req.writedata < NUM_OUTPUTS
    |=> sel_reg == $past(bus_req.writedata[SEL_W-1:0]))
    else $error("selector write not loaded");

  a_sel_bad_kept: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_SELECTOR
    && bus_req.writedata >= NUM_OUTPUTS
    |=> $stable(sel_reg))
    else $error("out of range selector accepted");

  a_sel_readback: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read && bus_req.address == `OFS_BIT_SELECTOR
    |=> bus_rsp.readdata == 32'($past(sel_reg)))
    else $error("selector readback wrong");

  a_word_masked_load: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE
    && &bus_req.byteenable
    |=> ((out_reg ^ $past(bus_req.writedata[NUM_OUTPUTS-1:0])) & $past(mask_reg)) == '0)
    else $error("enabled bit not written");

  a_lane_off_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE
    && !bus_req.byteenable[0]
    |=> ((out_reg ^ $past(out_reg)) & NUM_OUTPUTS'(32'h000000ff)) == '0)
    else $error("disabled lane changed");

  a_bit_lane_off: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_VALUE
    && !bus_req.byteenable[0]
    |=> $stable(out_reg))
    else $error("bit write without lane applied");

  a_mask_write_load: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_MASK
    && &bus_req.byteenable
    |=> mask_reg == $past(bus_req.writedata[NUM_OUTPUTS-1:0]))
    else $error("mask write not loaded");

  a_mask_only_write: assert property (@(posedge clk) disable iff (!rst_n)
    !(fire && bus_req.write && bus_req.address == `OFS_WORD_MASK)
    |=> $stable(mask_reg))
    else $error("mask changed without write");

  a_out_only_write: assert property (@(posedge clk) disable iff (!rst_n)
    !(fire && bus_req.write)
    |=> $stable(out_reg))
    else $error("outputs changed without write");

  a_bitval_readback: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read && bus_req.address == `OFS_BIT_VALUE
    |=> bus_rsp.readdata == 32'($past(out_reg[sel_reg])))
    else $error("bit readback wrong");

  a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read && !(bus_req.address inside {`OFS_BIT_SELECTOR,
    `OFS_BIT_VALUE, `OFS_WORD_VALUE, `OFS_WORD_MASK})
    |=> bus_rsp.readdata == `UNMAPPED_READ)
    else $error("unmapped read not zero");

  a_read_no_side: assert property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.read
    |=> $stable(out_reg) && $stable(mask_reg) && $stable(sel_reg))
    else $error("read changed state");

  // One wait cycle, then the answer stands for exactly one cycle
  a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    fire |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest)
    else $error("answer timing wrong");

  // Reset is checked at release, since the other checks are off during it
  a_reset_lines: assert property (@(posedge clk)
    $rose(rst_n) |-> line_drive_source == '0 && out_reg == '0)
    else $error("outputs not low after reset");

  a_reset_mask: assert property (@(posedge clk)
    $rose(rst_n) |-> mask_reg == NUM_OUTPUTS'(`MASK_RESET) && sel_reg == '0)
    else $error("mask or selector reset wrong");

  c_bit_write: cover property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_BIT_VALUE);
  c_word_write_masked: cover property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_VALUE && mask_reg != '1);
  c_mask_write: cover property (@(posedge clk) disable iff (!rst_n)
    fire && bus_req.write && bus_req.address == `OFS_WORD_MASK);
  c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
    fire ##3 fire);
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the soft output register block
`timescale 1ns/100ps
`default_nettype none
`include "soft_output_defs.svh"
module tb_top
  import soft_output_pkg::*;
;
  localparam int N = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  avmm_req_s req = '0;
  avmm_rsp_s rsp;
  logic [N-1:0] lines;
  logic [31:0] q;
  logic [31:0] e;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  user_output_register #(.NUM_OUTPUTS(N)) user_output_register_inst (
    .clk(clk),
    .rst_n(rst_n),
    .bus_req(req),
    .bus_rsp(rsp),
    .line_drive_source(lines)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Reporting
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Generous ceiling: the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_lines(input logic [31:0] exp);
    @(negedge clk);
    chk({24'h0, lines}, exp);
  endtask

  // ==========================================================
  // Bus master: request held until waitrequest is sampled low
  task automatic access(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    req.read <= ~w;
    req.write <= w;
    do @(posedge clk); while (rsp.waitrequest !== 1'b0);
    q = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    access(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_lines(32'h0);
    rd(`OFS_WORD_VALUE, `OUT_RESET);
    rd(`OFS_WORD_MASK, `MASK_RESET >> (32 - N));
    rd(`OFS_BIT_SELECTOR, 32'h0);
    $display("test reset done");
    wr(`OFS_WORD_VALUE, 32'h000000a5);
    chk_lines(32'h000000a5);
    rd(`OFS_WORD_VALUE, 32'h000000a5);
    $display("test word write done");
    wr(`OFS_WORD_MASK, 32'h0000000f);
    rd(`OFS_WORD_MASK, 32'h0000000f);
    wr(`OFS_WORD_VALUE, 32'h0000005a);
    chk_lines(32'h000000aa);
    wr(`OFS_WORD_MASK, 32'h000000f0);
    wr(`OFS_WORD_VALUE, 32'h00000000);
    chk_lines(32'h0000000a);
    $display("test mask done");
    // Mask blocks the lower nibble, so bit writes there prove it is bypassed
    e = 32'h0000000a;
    for (int i = 0; i < N; i++) begin
      wr(`OFS_BIT_SELECTOR, i);
      rd(`OFS_BIT_SELECTOR, i);
      e[i] = ~e[i];
      wr(`OFS_BIT_VALUE, {31'h0, e[i]});
      chk_lines(e);
      rd(`OFS_BIT_VALUE, {31'h0, e[i]});
    end
    $display("test bit writes done");
    wr(`OFS_BIT_SELECTOR, N);
    rd(`OFS_BIT_SELECTOR, N - 1);
    e[N-1] = 1'b0;
    wr(`OFS_BIT_VALUE, 32'h0);
    chk_lines(e);
    wr(4'h2, 32'h000000ff);
    chk_lines(e);
    rd(4'h2, `UNMAPPED_READ);
    $display("test refusals done");
    give_verdict();
  end
endmodule
`default_nettype wire
